// ==== core/cas_pkg.sv ====
// shared constants, types and slot mapping for the codec audio serial port
package cas_pkg;

    // ========================================================
    // register map (word index on the device's register port)
    localparam logic [7:0]  REG_CTRL1     = 8'h1c;
    localparam logic [7:0]  REG_CTRL2     = 8'h1d;
    localparam logic [7:0]  REG_ADC_SLOTS = 8'h1e;
    localparam logic [7:0]  REG_DAC_SLOTS = 8'h1f;
    localparam logic [7:0]  REG_STATUS    = 8'h20;
    localparam logic [15:0] CTRL1_RST     = 16'h0000;
    localparam logic [15:0] CTRL2_RST     = 16'h0000;
    localparam logic [15:0] SLOTS_RST     = 16'h0000;

    // audio_port_control_one fields
    localparam int F_FMT_LO  = 0;
    localparam int F_TDM     = 2;
    localparam int F_IDLE_LO = 4;
    localparam int F_POL     = 6;
    localparam int F_SWAP_LO = 8;
    // audio_port_control_two fields
    localparam int F_MS      = 3;
    localparam int F_TS      = 10;

    localparam logic [1:0] FMT_RJ   = 2'h0;
    localparam logic [1:0] FMT_LJ   = 2'h1;
    localparam logic [1:0] FMT_I2S  = 2'h2;
    localparam logic [1:0] IDLE_UP  = 2'h1;
    localparam logic [1:0] IDLE_HIZ = 2'h3;

    // ========================================================
    // frame geometry and timing
    localparam logic [7:0] WORD_BITS     = 8'h10;
    localparam logic [7:0] HALF_BCLK     = 8'h20;
    localparam int         SYS_CLK_NS    = 20;
    localparam int         BCLK_PERIOD_NS = 160;
    localparam logic [7:0] BCLK_HALF     = 8'(BCLK_PERIOD_NS / (2 * SYS_CLK_NS));

    typedef enum logic [6:0] {
        CAS_RJ     = 7'h01,
        CAS_LJ     = 7'h02,
        CAS_I2S    = 7'h04,
        CAS_PCMA   = 7'h08,
        CAS_PCMB   = 7'h10,
        CAS_TSLOT  = 7'h20,
        CAS_TDMOFF = 7'h40
    } cas_mode_t;

    typedef struct packed {
        logic       hit;
        logic [1:0] ch;
        logic [3:0] idx;
    } cas_slot_t;

    // ========================================================
    // format decode shared by both ends
    function automatic cas_mode_t mode_of(logic [1:0] fmt, logic pol, logic ts, logic tdm);
        if (fmt == FMT_RJ)
            return CAS_RJ;
        else if (fmt == FMT_LJ)
            return CAS_LJ;
        else if (fmt == FMT_I2S)
            return CAS_I2S;
        else if (ts)
            return tdm ? CAS_TDMOFF : CAS_TSLOT;
        else
            return pol ? CAS_PCMB : CAS_PCMA;
    endfunction

    // frame-pulse formats restart the frame only on the rising sync edge
    function automatic logic is_pcm(cas_mode_t m);
        return m inside {CAS_PCMA, CAS_PCMB, CAS_TSLOT, CAS_TDMOFF};
    endfunction

    function automatic logic is_slotted(cas_mode_t m);
        return m inside {CAS_TSLOT, CAS_TDMOFF};
    endfunction

    // sync level a master drives for frame bit-clock count mc
    function automatic logic fs_gen(cas_mode_t m, logic [5:0] mc);
        if (is_pcm(m))
            return mc == 6'h00;
        else if (m == CAS_I2S)
            return {2'b00, mc} >= HALF_BCLK;
        else
            return {2'b00, mc} < HALF_BCLK;
    endfunction

    // which channel and bit a rising edge carries; pos counts edges from the
    // edge that first sees the new sync level (pos 0)
    function automatic cas_slot_t slot_map(cas_mode_t m, logic tdm, logic [7:0] pos,
                                           logic fs, logic [7:0] offl, logic [7:0] offr);
        cas_slot_t  s;
        logic [7:0] off;
        logic [7:0] span;
        logic [7:0] rel;
        logic       rgt;
        s    = '0;
        rgt  = (pos >= offr) && (8'(pos - offr) < WORD_BITS);
        off  = 8'h00;
        span = WORD_BITS;
        unique case (m)
            CAS_RJ:     off = 8'(HALF_BCLK - WORD_BITS);          // RULE6 RULE19
            CAS_LJ:     off = 8'h00;                              // RULE7
            CAS_I2S:                                              // RULE8 RULE14
            begin
                off  = 8'h01;
                span = tdm ? 8'(2 * WORD_BITS) : WORD_BITS;
            end
            CAS_PCMA:   begin off = 8'h01; span = 8'(WORD_BITS * (tdm ? 4 : 2)); end // RULE9 RULE15
            CAS_PCMB:   begin off = 8'h00; span = 8'(WORD_BITS * (tdm ? 4 : 2)); end // RULE10 RULE16
            CAS_TSLOT:  off = rgt ? offr : offl;                  // RULE11
            CAS_TDMOFF: begin off = offl; span = 8'(4 * WORD_BITS); end // RULE17
        endcase
        rel   = 8'(pos - off);
        s.hit = (pos >= off) && (rel < span);
        s.idx = 4'hf - rel[3:0];
        if (m == CAS_RJ || m == CAS_LJ)
            s.ch = {1'b0, ~fs};
        else if (m == CAS_I2S)
            s.ch = {rel[4], fs};
        else if (m == CAS_TSLOT)
            s.ch = {1'b0, rgt};
        else
            s.ch = rel[5:4];
        return s;
    endfunction

endpackage

// ==== core/cas_link_if.sv ====
// serial audio link between the codec port and the host controller
`timescale 1ns/10ps
interface cas_link_if;
    logic bclk_d_o;
    logic bclk_d_oe;
    logic fs_d_o;
    logic fs_d_oe;
    logic adc_o;
    logic adc_oe;
    logic bclk_h_o;
    logic bclk_h_oe;
    logic fs_h_o;
    logic fs_h_oe;
    logic dac_o;
    logic bclk;
    logic fs;
    logic adc;
    logic dac;

    // wire levels; an undriven line reads low
    assign bclk = bclk_d_oe ? bclk_d_o : (bclk_h_oe & bclk_h_o);
    assign fs   = fs_d_oe ? fs_d_o : (fs_h_oe & fs_h_o);
    assign adc  = adc_oe & adc_o;
    assign dac  = dac_o;

    modport dev  (output bclk_d_o, bclk_d_oe, fs_d_o, fs_d_oe, adc_o, adc_oe,
                  input bclk, fs, dac);
    modport host (output bclk_h_o, bclk_h_oe, fs_h_o, fs_h_oe, dac_o,
                  input bclk, fs, adc);
endinterface

// ==== core/cas_device.sv ====
// codec end of the audio serial port: registers, clocking, adc out, dac in
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps

// Function
// [RULE1] master select bit, slave after reset
// [RULE2] master drives clock and sync, else host
// [RULE3] data sampled on rising bit clock
// [RULE4] idle output low, or pulled up/down
// [RULE5] format, polarity and time-slot select fields
// [RULE6] right-justified: LSB before sync edge
// [RULE7] left-justified: MSB first edge after
// [RULE8] I2S: MSB second edge, left low
// [RULE9] PCM A: MSB second edge after rise
// [RULE10] PCM B: MSB first edge after rise
// [RULE11] time-slot: separate programmable channel starts
// [RULE12] time-slot: swap or duplicate channels
// [RULE13] slot idle: up, down or released
// [RULE14] TDM I2S: four channels, two per half
// [RULE15] TDM PCM A: four channels back to back
// [RULE16] TDM PCM B: MSB first edge after rise
// [RULE17] TDM offset: programmable start delay count
// [RULE18] output bits launched on falling edge
// [RULE19] sixteen-bit words, format zero right-justified
// [RULE20] master divides system clock for link
module cas_device (
    input  logic        i_sys_clk,
    input  logic        i_rst,
    input  logic [7:0]  i_addr,
    input  logic [15:0] i_wdata,
    input  logic        i_wr,
    input  logic        i_rd,
    output logic [15:0] o_rdata,
    input  logic [15:0] i_adc_ch0,
    input  logic [15:0] i_adc_ch1,
    output logic        o_adc_take,
    output logic [15:0] o_dac_word,
    output logic        o_dac_ch,
    output logic        o_dac_valid,
    cas_link_if.dev     link
);
    logic [15:0]       ctrl1;
    logic [15:0]       ctrl2;
    logic [15:0]       adc_slots;
    logic [15:0]       dac_slots;
    cas_pkg::cas_mode_t mode;
    logic              master;
    logic              tdm;
    logic [1:0]        idle;
    logic [1:0]        swap;
    logic [7:0]        div_cnt;
    logic              bclk_q;
    logic              m_rise;
    logic              m_fall;
    logic              fall;
    logic              rise;
    logic [5:0]        mc;
    logic [5:0]        next_mc;
    logic              fs_m;
    logic              fs_now;
    logic              fs_q;
    logic              trans;
    logic [7:0]        pos;
    logic [7:0]        next_pos;
    logic              bclk_s1;
    logic              bclk_s2;
    logic              bclk_s3;
    logic              fs_s1;
    logic              fs_s2;
    logic              din_s1;
    logic              din_s2;
    logic [15:0]       w0;
    logic [15:0]       w1;
    logic [15:0]       tx_word;
    logic              tx_src;
    logic [15:0]       sreg;
    cas_pkg::cas_slot_t tx;
    cas_pkg::cas_slot_t rx;

    // channel exchange or duplication, only in the slot modes
    function automatic logic remap(logic [1:0] sw, logic ch, logic slotted);
        if (!slotted)
            return ch;
        else if (sw == 2'h1)
            return ~ch;
        else if (sw == 2'h2)
            return 1'b0;
        else if (sw == 2'h3)
            return 1'b1;
        else
            return ch;
    endfunction

    // ========================================================
    // register port
    assign master = ctrl2[cas_pkg::F_MS];                                  // RULE1
    assign tdm    = ctrl1[cas_pkg::F_TDM];
    assign idle   = ctrl1[cas_pkg::F_IDLE_LO +: 2];
    assign swap   = ctrl1[cas_pkg::F_SWAP_LO +: 2];
    assign mode   = cas_pkg::mode_of(ctrl1[cas_pkg::F_FMT_LO +: 2], ctrl1[cas_pkg::F_POL],
                                     ctrl2[cas_pkg::F_TS], tdm);          // RULE5 RULE19

    // writes; unmapped addresses are ignored
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            ctrl1     <= cas_pkg::CTRL1_RST;
            ctrl2     <= cas_pkg::CTRL2_RST;                               // RULE1
            adc_slots <= cas_pkg::SLOTS_RST;
            dac_slots <= cas_pkg::SLOTS_RST;
        end
        else if (i_wr)
        begin
            case (i_addr)
                cas_pkg::REG_CTRL1:     ctrl1 <= i_wdata;
                cas_pkg::REG_CTRL2:     ctrl2 <= i_wdata;
                cas_pkg::REG_ADC_SLOTS: adc_slots <= i_wdata;              // RULE11
                cas_pkg::REG_DAC_SLOTS: dac_slots <= i_wdata;
                default:                ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || !i_rd)
            o_rdata <= 16'h0000;
        else
        begin
            case (i_addr)
                cas_pkg::REG_CTRL1:     o_rdata <= ctrl1;
                cas_pkg::REG_CTRL2:     o_rdata <= ctrl2;
                cas_pkg::REG_ADC_SLOTS: o_rdata <= adc_slots;
                cas_pkg::REG_DAC_SLOTS: o_rdata <= dac_slots;
                cas_pkg::REG_STATUS:    o_rdata <= {6'h00, master, fs_q, pos};
                default:                o_rdata <= 16'h0000;
            endcase
        end
    end

    // ========================================================
    // link clocking
    // pins pass two flops; edges are found on the second and third
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
            {fs_s1, fs_s2, din_s1, din_s2} <= 4'h0;
        end
        else
        begin
            {bclk_s1, bclk_s2, bclk_s3} <= {link.bclk, bclk_s1, bclk_s2};
            {fs_s1, fs_s2} <= {link.fs, fs_s1};
            {din_s1, din_s2} <= {link.dac, din_s1};
        end
    end

    // bit clock divider, held still while slave
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || !master)
        begin
            div_cnt <= 8'h00;
            bclk_q  <= 1'b0;
        end
        else if (div_cnt == 8'(cas_pkg::BCLK_HALF - 8'h01))
        begin
            div_cnt <= 8'h00;
            bclk_q  <= ~bclk_q;                                            // RULE20
        end
        else
            div_cnt <= 8'(div_cnt + 8'h01);
    end

    assign m_rise  = master && (div_cnt == 8'(cas_pkg::BCLK_HALF - 8'h01)) && !bclk_q;
    assign m_fall  = master && (div_cnt == 8'(cas_pkg::BCLK_HALF - 8'h01)) && bclk_q;
    // a master launches on its own edge; receive always uses the pin view so the
    // far end's launch delay through its synchroniser is matched
    assign fall    = master ? m_fall : (~bclk_s2 & bclk_s3);               // RULE18
    assign rise    = bclk_s2 & ~bclk_s3;                                   // RULE3
    assign next_mc = 6'(mc + 6'h01);

    // frame counter and generated sync, both moving on the falling edge
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            mc   <= 6'h00;
            fs_m <= 1'b0;
        end
        else if (m_fall)
        begin
            mc   <= next_mc;
            fs_m <= cas_pkg::fs_gen(mode, next_mc);                        // RULE20
        end
    end

    assign link.bclk_d_o  = bclk_q;
    assign link.bclk_d_oe = master;                                        // RULE2
    assign link.fs_d_o    = fs_m;
    assign link.fs_d_oe   = master;                                        // RULE2

    // ========================================================
    // frame position: pos names the rising edge that follows each fall
    assign fs_now   = master ? cas_pkg::fs_gen(mode, next_mc) : fs_s2;
    assign trans    = cas_pkg::is_pcm(mode) ? (fs_now & ~fs_q) : (fs_now ^ fs_q);
    assign next_pos = trans ? 8'h00 : ((pos == 8'hff) ? pos : 8'(pos + 8'h01));
    assign tx = cas_pkg::slot_map(mode, tdm, next_pos, fs_now, adc_slots[7:0], adc_slots[15:8]);
    assign rx = cas_pkg::slot_map(mode, tdm, pos, fs_q, dac_slots[7:0], dac_slots[15:8]);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            fs_q <= 1'b0;
            pos  <= 8'hff;
        end
        else if (fall)
        begin
            fs_q <= fs_now;
            pos  <= next_pos;
        end
    end

    // ========================================================
    // adc transmit: words taken at each frame edge, bits launched on fall
    assign tx_src  = remap(swap, tx.ch[0], cas_pkg::is_slotted(mode));    // RULE12
    assign tx_word = trans ? (tx_src ? i_adc_ch1 : i_adc_ch0) : (tx_src ? w1 : w0);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            w0         <= 16'h0000;
            w1         <= 16'h0000;
            o_adc_take <= 1'b0;
        end
        else
        begin
            o_adc_take <= fall && trans;
            if (fall && trans)
            begin
                w0 <= i_adc_ch0;
                w1 <= i_adc_ch1;
            end
        end
    end

    // channels 2 and 3 of the four-channel formats carry nothing from here
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            link.adc_o  <= 1'b0;                                           // RULE4
            link.adc_oe <= 1'b1;
        end
        else if (fall)                                                     // RULE18
        begin
            if (tx.hit && !tx.ch[1])
            begin
                link.adc_o  <= tx_word[tx.idx];                            // RULE3
                link.adc_oe <= 1'b1;
            end
            else
            begin
                link.adc_o  <= (idle == cas_pkg::IDLE_UP);                 // RULE4
                link.adc_oe <= !((idle == cas_pkg::IDLE_HIZ)
                                 && cas_pkg::is_slotted(mode));            // RULE13
            end
        end
    end

    // ========================================================
    // dac receive on the rising edge, word handed out after its LSB
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            sreg        <= 16'h0000;
            o_dac_word  <= 16'h0000;
            o_dac_ch    <= 1'b0;
            o_dac_valid <= 1'b0;
        end
        else
        begin
            o_dac_valid <= 1'b0;
            if (rise && rx.hit && !rx.ch[1])                               // RULE3
            begin
                sreg <= {sreg[14:0], din_s2};
                if (rx.idx == 4'h0)
                begin
                    o_dac_word  <= {sreg[14:0], din_s2};
                    o_dac_ch    <= remap(swap, rx.ch[0], cas_pkg::is_slotted(mode)); // RULE12
                    o_dac_valid <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== core/cas_host.sv ====
// host controller end of the audio serial port
`timescale 1ns/10ps
module cas_host (
    input  logic        i_sys_clk,
    input  logic        i_rst,
    input  logic        i_master,
    input  logic [1:0]  i_fmt,
    input  logic        i_pol,
    input  logic        i_ts,
    input  logic        i_tdm,
    input  logic [15:0] i_adc_slots,
    input  logic [15:0] i_dac_slots,
    input  logic [15:0] i_dac_ch0,
    input  logic [15:0] i_dac_ch1,
    output logic [15:0] o_adc_word,
    output logic [1:0]  o_adc_ch,
    output logic        o_adc_valid,
    cas_link_if.host    link
);
    cas_pkg::cas_mode_t mode;
    logic [7:0]        div_cnt;
    logic              bclk_q;
    logic              m_fall;
    logic              fall;
    logic              rise;
    logic [5:0]        mc;
    logic [5:0]        next_mc;
    logic              fs_m;
    logic              fs_now;
    logic              fs_q;
    logic              trans;
    logic [7:0]        pos;
    logic [7:0]        next_pos;
    logic [2:0]        bclk_s;
    logic [1:0]        fs_s;
    logic [1:0]        din_s;
    logic [15:0]       w0;
    logic [15:0]       w1;
    logic [15:0]       sreg;
    cas_pkg::cas_slot_t tx;
    cas_pkg::cas_slot_t rx;

    assign mode = cas_pkg::mode_of(i_fmt, i_pol, i_ts, i_tdm);

    // ========================================================
    // link clocking, mirrored from the codec end
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            bclk_s <= 3'h0;
            fs_s   <= 2'h0;
            din_s  <= 2'h0;
        end
        else
        begin
            bclk_s <= {bclk_s[1:0], link.bclk};
            fs_s   <= {fs_s[0], link.fs};
            din_s  <= {din_s[0], link.adc};
        end
    end

    // divider runs only while this end owns the clock
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || !i_master)
        begin
            div_cnt <= 8'h00;
            bclk_q  <= 1'b0;
        end
        else if (div_cnt == 8'(cas_pkg::BCLK_HALF - 8'h01))
        begin
            div_cnt <= 8'h00;
            bclk_q  <= ~bclk_q;                                            // RULE2
        end
        else
            div_cnt <= 8'(div_cnt + 8'h01);
    end

    assign m_fall  = i_master && (div_cnt == 8'(cas_pkg::BCLK_HALF - 8'h01)) && bclk_q;
    assign fall    = i_master ? m_fall : (~bclk_s[1] & bclk_s[2]);
    assign rise    = bclk_s[1] & ~bclk_s[2];                               // RULE3
    assign next_mc = 6'(mc + 6'h01);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            mc   <= 6'h00;
            fs_m <= 1'b0;
        end
        else if (m_fall)
        begin
            mc   <= next_mc;
            fs_m <= cas_pkg::fs_gen(mode, next_mc);
        end
    end

    assign link.bclk_h_o  = bclk_q;
    assign link.bclk_h_oe = i_master;                                      // RULE2
    assign link.fs_h_o    = fs_m;
    assign link.fs_h_oe   = i_master;

    // ========================================================
    // frame position, as on the codec end
    assign fs_now   = i_master ? cas_pkg::fs_gen(mode, next_mc) : fs_s[1];
    assign trans    = cas_pkg::is_pcm(mode) ? (fs_now & ~fs_q) : (fs_now ^ fs_q);
    assign next_pos = trans ? 8'h00 : ((pos == 8'hff) ? pos : 8'(pos + 8'h01));
    assign tx = cas_pkg::slot_map(mode, i_tdm, next_pos, fs_now, i_dac_slots[7:0],
                                  i_dac_slots[15:8]);
    assign rx = cas_pkg::slot_map(mode, i_tdm, pos, fs_q, i_adc_slots[7:0], i_adc_slots[15:8]);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            fs_q <= 1'b0;
            pos  <= 8'hff;
        end
        else if (fall)
        begin
            fs_q <= fs_now;
            pos  <= next_pos;
        end
    end

    // dac words taken at each frame edge; channels 2 and 3 repeat 0 and 1
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            w0 <= 16'h0000;
            w1 <= 16'h0000;
        end
        else if (fall && trans)
        begin
            w0 <= i_dac_ch0;
            w1 <= i_dac_ch1;
        end
    end

    // dac line always driven, low outside its slots
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            link.dac_o <= 1'b0;
        else if (fall)
        begin
            if (!tx.hit)
                link.dac_o <= 1'b0;
            else if (trans)
                link.dac_o <= tx.ch[0] ? i_dac_ch1[tx.idx] : i_dac_ch0[tx.idx];
            else
                link.dac_o <= tx.ch[0] ? w1[tx.idx] : w0[tx.idx];
        end
    end

    // ========================================================
    // adc receive on the rising edge
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            sreg        <= 16'h0000;
            o_adc_word  <= 16'h0000;
            o_adc_ch    <= 2'h0;
            o_adc_valid <= 1'b0;
        end
        else
        begin
            o_adc_valid <= 1'b0;
            if (rise && rx.hit)                                            // RULE3
            begin
                sreg <= {sreg[14:0], din_s[1]};
                if (rx.idx == 4'h0)
                begin
                    o_adc_word  <= {sreg[14:0], din_s[1]};
                    o_adc_ch    <= rx.ch;
                    o_adc_valid <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== tb/cas_sva.sv ====
// assertions on the codec side of the serial audio link
`timescale 1ns/10ps
module cas_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic bclk_d_o,
    input wire logic bclk_d_oe,
    input wire logic fs_d_o,
    input wire logic fs_d_oe,
    input wire logic adc_o,
    input wire logic adc_oe,
    input wire logic bclk
);
    // ==========================================================
    // link checks, one clock domain
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    property p_slave; $past(i_rst) |-> !bclk_d_oe && !fs_d_oe; endproperty
    a_slave: assert property (p_slave) else $error("link driven after reset");
    property p_own; bclk_d_oe == fs_d_oe; endproperty
    a_own: assert property (p_own) else $error("clock and sync owned apart");
    // divider of four system cycles per half period
    property p_half; bclk_d_oe && $rose(bclk_d_o) |=> bclk_d_o [*3] ##1 !bclk_d_o; endproperty
    a_half: assert property (p_half) else $error("bad bit clock half");
    property p_start; $rose(bclk_d_oe) |-> ##[1:9] $rose(bclk_d_o); endproperty
    a_start: assert property (p_start) else $error("bit clock did not start");
    // sync moves only while the clock is low, so it is settled at the rise
    property p_fs; fs_d_oe && $changed(fs_d_o) |-> !bclk_d_o; endproperty
    a_fs: assert property (p_fs) else $error("sync moved with clock high");
    property p_launch; $changed(adc_o) |-> !bclk; endproperty
    a_launch: assert property (p_launch) else $error("data moved with clock high");
    property p_release; $fell(adc_oe) |-> !bclk; endproperty
    a_release: assert property (p_release) else $error("release off the fall");
    property p_idle; $past(i_rst) |-> adc_oe && !adc_o; endproperty
    a_idle: assert property (p_idle) else $error("output not low after reset");
endmodule

// ==== tb/cas_tb.sv ====
// bench joining the codec end and the host end over the link
`timescale 1ns/10ps
module cas_tb;
    cas_link_if  link ();
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [15:0] c1 = 16'h0000;
    logic        ts = 1'b0;
    logic        h_ms = 1'b0;
    logic [15:0] w0 = 16'ha5c3;
    logic [15:0] w1 = 16'h9669;
    logic [15:0] slots = 16'h1403;
    logic [15:0] rdata, h_word, d_word;
    logic [1:0]  h_ch;
    logic        h_val, d_ch, d_val;
    int          error_cnt = 0;
    int          cmp_count = 0;
    wire  [3:0]  ev = {d_val, h_val, link.fs, link.bclk};
    // ==========================================================
    // clock, the two ends and the checker
    always #10 clk = ~clk;
    cas_device u_cas_device (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_adc_ch0(w0), .i_adc_ch1(w1),
        .o_adc_take(), .o_dac_word(d_word), .o_dac_ch(d_ch), .o_dac_valid(d_val), .link(link));
    cas_host u_cas_host (.i_sys_clk(clk), .i_rst(rst), .i_master(h_ms), .i_fmt(c1[1:0]),
        .i_pol(c1[6]), .i_ts(ts), .i_tdm(c1[2]), .i_adc_slots(slots), .i_dac_slots(slots),
        .i_dac_ch0(w1), .i_dac_ch1(w0), .o_adc_word(h_word), .o_adc_ch(h_ch),
        .o_adc_valid(h_val), .link(link));
    cas_sva u_cas_sva (.i_sys_clk(clk), .i_rst(rst), .bclk_d_o(link.bclk_d_o),
        .bclk_d_oe(link.bclk_d_oe), .fs_d_o(link.fs_d_o), .fs_d_oe(link.fs_d_oe),
        .adc_o(link.adc_o), .adc_oe(link.adc_oe), .bclk(link.bclk));
    // verdict and comparison helpers
    task automatic final_report;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for a rising or falling event; a hang ends the run
    task automatic w_ev(input int i, input logic lvl);
        logic p;
        p = ev[i];
        repeat (3000)
        begin
            @(posedge clk);
            #1;
            if (ev[i] === lvl && p !== lvl)
                return;
            p = ev[i];
        end
        chk(16'hdead, 16'h0000);
        final_report;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // first channel-0 word delivered at end i (2 host, 3 codec)
    task automatic rx(input int i, input logic [15:0] e);
        repeat (4)
        begin
            w_ev(i, 1'b1);
            if ((i == 2 ? h_ch : {1'b0, d_ch}) === 2'h0)
            begin
                chk(i == 2 ? h_word : d_word, e);
                return;
            end
        end
        chk(16'hdead, e);
    endtask
    // configure with the link clock stopped, then probe edges k, k+1, k+16
    task automatic run(input logic [15:0] c, input logic t, input logic m, input int k,
                       input logic [2:0] e);
        logic [2:0] g;
        @(posedge clk);
        h_ms <= 1'b0;
        wr(8'h1c, c);
        wr(8'h1d, {5'h00, t, 6'h00, m, 3'h0});
        c1 <= c;
        ts <= t;
        h_ms <= !m;
        repeat (2) w_ev(1, c[1:0] != 2'h2);
        repeat (k + 1) w_ev(0, 1'b1);
        g[2] = link.adc;
        w_ev(0, 1'b1);
        g[1] = link.adc;
        repeat (15) w_ev(0, 1'b1);
        g[0] = link.adc;
        chk({13'h0, g}, {13'h0, e});
        rx(2, w0);
        rx(3, w1);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'h1d, 16'h0000);
        wr(8'h1e, slots);
        wr(8'h1f, slots);
        rd(8'h1f, 16'h1403);
        rd(8'h21, 16'h0000);
        run(16'h0010, 1'b0, 1'b0, 16, 3'h5);
        run(16'h0011, 1'b0, 1'b0, 0, 3'h5);
        run(16'h0012, 1'b0, 1'b0, 1, 3'h5);
        run(16'h0013, 1'b0, 1'b0, 1, 3'h5);
        run(16'h0053, 1'b0, 1'b0, 0, 3'h5);
        run(16'h0017, 1'b0, 1'b0, 1, 3'h5);
        run(16'h0033, 1'b1, 1'b0, 3, 3'h4);
        run(16'h0057, 1'b0, 1'b0, 0, 3'h5);
        run(16'h0037, 1'b1, 1'b0, 3, 3'h5);
        run(16'h0011, 1'b0, 1'b1, 0, 3'h5);
        rd(8'h1d, 16'h0008);
        final_report;
    end
endmodule
